/* logic/spi_sd_pkg.sv */
// package for the serial status and data path block
// holds register offsets, field positions, reset values and shared types
package spi_sd_pkg;

  // --------------------------------------------------------------------
  // register map (byte addresses on a 32-bit wishbone bus)
  // --------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;  // control bits
  localparam logic [3:0] STATUS_OFFSET = 4'h4;  // serial_status_control
  localparam logic [3:0] DATA_OFFSET   = 4'h8;  // serial_data_buffer

  // --------------------------------------------------------------------
  // control register field positions
  // --------------------------------------------------------------------
  localparam int CTRL_RX_IE_BIT  = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_TX_IE_BIT  = 2;
  localparam int CTRL_ENABLE_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h02;    // master mode after reset

  // --------------------------------------------------------------------
  // status/control register field positions
  // --------------------------------------------------------------------
  localparam int ST_RATE_LOW_BIT  = 0;
  localparam int ST_RATE_HIGH_BIT = 1;
  localparam int ST_MODE_FAULT_FLAG_EN_BIT   = 2;
  localparam int ST_TX_EMPTY_BIT  = 3;
  localparam int ST_MODE_FAULT_FLAG_BIT      = 4;
  localparam int ST_OVR_BIT       = 5;
  localparam int ST_ERR_IE_BIT    = 6;
  localparam int ST_RX_FULL_BIT   = 7;

  // --------------------------------------------------------------------
  // rate divisors and counts
  // --------------------------------------------------------------------
  localparam logic [7:0] DIV_CODE0 = 8'h02;
  localparam logic [7:0] DIV_CODE1 = 8'h08;
  localparam logic [7:0] DIV_CODE2 = 8'h20;
  localparam logic [7:0] DIV_CODE3 = 8'h80;
  localparam logic [2:0] BITS_PER_BYTE = 3'h7;  // last bit index

  // transfer state
  typedef enum logic [1:0] {
    IDLE_ST  = 2'b00,
    SHIFT_ST = 2'b01,
    DONE_ST  = 2'b10
  } xfer_state_type;

  // serial pin group carried together
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pin_group_type;

endpackage

/* logic/spi_status_data_path.sv */
// serial peripheral status, error, baud and data buffering block
// assumes a classic wishbone master on MCLK_IN and an external spi partner;
// pins arrive asynchronous and are double registered before use
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps

module spi_status_data_path
  import spi_sd_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  // wishbone slave
  input  wire logic        CYC_IN,
  input  wire logic        STB_IN,
  input  wire logic        WE_IN,
  input  wire logic [3:0]  ADR_IN,
  input  wire logic [3:0]  SEL_IN,
  input  wire logic [31:0] DAT_IN,
  output logic      [31:0] DAT_OUT,
  output logic             ACK_OUT,
  // serial pins
  input  wire logic        SCK_IN,
  input  wire logic        MOSI_IN,
  input  wire logic        MISO_IN,
  input  wire logic        SS_N_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE_OUT,
  output logic             MOSI_OUT,
  output logic             MOSI_OE_OUT,
  output logic             MISO_OUT,
  output logic             MISO_OE_OUT,
  output logic             SS_IS_INPUT_OUT,
  // interrupt request
  output logic             IRQ_OUT
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  pin_group_type  pin_meta_q;
  pin_group_type  pin_q;
  logic           sck_prev_q;
  logic           ss_prev_q;

  // first stage is read only by the second stage
  always_ff @(posedge MCLK_IN) begin
    pin_meta_q <= '{sck: SCK_IN, mosi: MOSI_IN, miso: MISO_IN, ss_n: SS_N_IN};
    pin_q      <= pin_meta_q;
    sck_prev_q <= pin_q.sck;
    ss_prev_q  <= pin_q.ss_n;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0]     ctrl_q;
  logic           rate_hi_q;
  logic           rate_lo_q;
  logic           mode_fault_flag_en_q;
  logic           err_ie_q;
  logic           rx_full_q;
  logic           ovr_q;
  logic           mode_fault_flag_q;
  logic           tx_empty_q;
  logic           ovr_armed_q;       // status read seen with overrun set
  logic           mode_fault_flag_armed_q;      // status read seen with mode fault set
  logic [7:0]     tx_buf_q;
  logic [7:0]     rx_buf_q;
  logic [7:0]     shift_q;
  logic           rx_bit_q;          // slave data bit held from rising to falling clock
  logic [2:0]     bit_cnt_q;
  xfer_state_type state_q;
  logic [7:0]     div_cnt_q;
  logic           sck_level_q;
  logic           master_edge_q;     // one-cycle enable from rate divider

  wire logic enable    = ctrl_q[CTRL_ENABLE_BIT];
  wire logic master    = ctrl_q[CTRL_MASTER_BIT];
  wire logic bus_req   = CYC_IN && STB_IN && !ACK_OUT;
  wire logic wr_data   = bus_req && WE_IN && ADR_IN == DATA_OFFSET && SEL_IN[0];
  wire logic rd_data   = bus_req && !WE_IN && ADR_IN == DATA_OFFSET;
  wire logic rd_status = bus_req && !WE_IN && ADR_IN == STATUS_OFFSET;
  wire logic wr_status = bus_req && WE_IN && ADR_IN == STATUS_OFFSET && SEL_IN[0];
  wire logic wr_ctrl   = bus_req && WE_IN && ADR_IN == CTRL_OFFSET && SEL_IN[0];

  // slave deselected: no output drive and clocks ignored
  wire logic slave_sel  = enable && !master && !pin_q.ss_n;
  wire logic slave_rise = slave_sel && !sck_prev_q && pin_q.sck;
  wire logic slave_fall = slave_sel && sck_prev_q && !pin_q.sck;
  wire logic m_active   = enable && master && state_q == SHIFT_ST;
  // a slave latches its data bit on the rising clock and shifts it in on the falling one
  wire logic sample_ev  = slave_rise && state_q == SHIFT_ST;
  wire logic shift_ev   = master ? (m_active && master_edge_q && sck_level_q) :
                                   (slave_fall && state_q == SHIFT_ST);
  // the master takes its input bit at the end of the high phase: the output flop and the
  // two synchroniser stages put three cycles between a partner's change and its sight here,
  // which the shortest half bit of two cycles could not cover at the rising clock
  wire logic in_bit     = master ? pin_q.miso : rx_bit_q;
  // a byte ends on its eighth falling clock, so the clock is back at idle when it lands
  wire logic byte_done  = shift_ev && bit_cnt_q == BITS_PER_BYTE;
  // idle shifter empty and a queued byte waiting
  wire logic load_ev    = enable && !tx_empty_q && state_q == IDLE_ST;

  // ------------------------------------------------------------------
  // wishbone slave: one wait state, ack drops after one cycle
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      ACK_OUT <= 1'b0;
      DAT_OUT <= 32'h0000_0000;
    end else begin
      ACK_OUT <= bus_req;
      DAT_OUT <= 32'h0000_0000;
      if (bus_req && !WE_IN) begin
        unique case (ADR_IN)
          CTRL_OFFSET:   DAT_OUT <= {24'h00_0000, ctrl_q};
          STATUS_OFFSET: DAT_OUT <= {24'h00_0000, rx_full_q, err_ie_q, ovr_q, mode_fault_flag_q,
                                     tx_empty_q, mode_fault_flag_en_q, rate_hi_q, rate_lo_q};
          DATA_OFFSET:   DAT_OUT <= {24'h00_0000, rx_buf_q};
          default:       DAT_OUT <= 32'h0000_0000;  // unmapped reads zero
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // control and status/control writable bits
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_q    <= CTRL_RESET;
      rate_hi_q <= 1'b0;
      rate_lo_q <= 1'b0;
      mode_fault_flag_en_q <= 1'b0;
      err_ie_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= DAT_IN[7:0];
      end
      if (wr_status) begin
        rate_hi_q <= DAT_IN[ST_RATE_HIGH_BIT];
        rate_lo_q <= DAT_IN[ST_RATE_LOW_BIT];
        mode_fault_flag_en_q <= DAT_IN[ST_MODE_FAULT_FLAG_EN_BIT];
        err_ie_q  <= DAT_IN[ST_ERR_IE_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // receive full and overrun flags, set wins over clear
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      rx_full_q   <= 1'b0;
      ovr_q       <= 1'b0;
      ovr_armed_q <= 1'b0;
      rx_buf_q    <= 8'h00;
    end else begin
      if (rd_status && ovr_q) begin
        ovr_armed_q <= 1'b1;
      end else if (rd_data) begin
        ovr_armed_q <= 1'b0;
      end
      if (rd_data) begin
        rx_full_q <= 1'b0;
      end
      if (rd_data && ovr_armed_q) begin
        ovr_q <= 1'b0;
      end
      if (byte_done) begin
        if (rx_full_q && !rd_data) begin
          ovr_q <= 1'b1;     // old byte kept, new one dropped
        end else begin
          rx_buf_q  <= {shift_q[6:0], in_bit};
          rx_full_q <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // mode fault detection
  // ------------------------------------------------------------------
  wire logic fault_ev = mode_fault_flag_en_q && enable &&
                        ((!master && state_q == SHIFT_ST && !ss_prev_q && pin_q.ss_n) ||
                         (master && !pin_q.ss_n));

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      mode_fault_flag_q       <= 1'b0;
      mode_fault_flag_armed_q <= 1'b0;
    end else begin
      if (rd_status && mode_fault_flag_q) begin
        mode_fault_flag_armed_q <= 1'b1;
      end else if (wr_data) begin
        mode_fault_flag_armed_q <= 1'b0;
      end
      if (fault_ev) begin
        mode_fault_flag_q <= 1'b1;
      end else if (wr_data && mode_fault_flag_armed_q) begin
        mode_fault_flag_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // transmit buffer and empty flag
  // ------------------------------------------------------------------
  // software keeps writes to while the flag is high; a late write overwrites the queued byte except in the load cycle, where it is lost
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      tx_buf_q   <= 8'h00;
      tx_empty_q <= 1'b1;
    end else begin
      if (load_ev) begin
        tx_empty_q <= 1'b1;
      end else if (wr_data) begin
        tx_buf_q   <= DAT_IN[7:0];
        tx_empty_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // master rate divider: base clock over twice the divisor
  // ------------------------------------------------------------------
  logic [7:0] divisor;
  always_comb begin
    unique case ({rate_hi_q, rate_lo_q})
      2'b00: divisor = DIV_CODE0;
      2'b01: divisor = DIV_CODE1;
      2'b10: divisor = DIV_CODE2;
      2'b11: divisor = DIV_CODE3;
    endcase
  end

  // each half bit lasts divisor cycles, so a full bit is twice that
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN || !m_active) begin
      div_cnt_q     <= 8'h00;
      master_edge_q <= 1'b0;
    end else if (div_cnt_q == divisor - 8'h01) begin
      div_cnt_q     <= 8'h00;
      master_edge_q <= 1'b1;
    end else begin
      div_cnt_q     <= div_cnt_q + 8'h01;
      master_edge_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // shift engine and transfer state
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN || !enable) begin
      state_q     <= IDLE_ST;
      shift_q     <= 8'h00;
      rx_bit_q    <= 1'b0;
      bit_cnt_q   <= 3'h0;
      sck_level_q <= 1'b0;
    end else begin
      unique case (state_q)
        IDLE_ST: begin
          if (load_ev) begin
            shift_q   <= tx_buf_q;
            bit_cnt_q <= 3'h0;
            state_q   <= SHIFT_ST;
          end
        end
        SHIFT_ST: begin
          if (master && master_edge_q) begin
            sck_level_q <= !sck_level_q;
          end
          if (sample_ev) begin
            rx_bit_q <= pin_q.mosi;
          end
          // outgoing bit leaves at the top while the incoming one enters at the bottom
          if (shift_ev) begin
            shift_q   <= {shift_q[6:0], in_bit};
            bit_cnt_q <= bit_cnt_q + 3'h1;
          end
          if (byte_done) begin
            sck_level_q <= 1'b0;
            state_q     <= IDLE_ST;
          end
        end
        DONE_ST: begin
          // not entered: a byte closes straight from the shift state
          state_q <= IDLE_ST;
        end
        default: state_q <= IDLE_ST;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // pin drivers and interrupt, all registered
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      SCK_OUT         <= 1'b0;
      SCK_OE_OUT      <= 1'b0;
      MOSI_OUT        <= 1'b0;
      MOSI_OE_OUT     <= 1'b0;
      MISO_OUT        <= 1'b0;
      MISO_OE_OUT     <= 1'b0;
      SS_IS_INPUT_OUT <= 1'b0;
      IRQ_OUT         <= 1'b0;
    end else begin
      SCK_OUT         <= sck_level_q;
      SCK_OE_OUT      <= enable && master;
      MOSI_OUT        <= shift_q[7];
      MOSI_OE_OUT     <= enable && master;
      MISO_OUT        <= shift_q[7];
      MISO_OE_OUT     <= slave_sel;
      SS_IS_INPUT_OUT <= enable && (!master || mode_fault_flag_en_q);
      IRQ_OUT         <= (rx_full_q && ctrl_q[CTRL_RX_IE_BIT]) ||
                         (tx_empty_q && ctrl_q[CTRL_TX_IE_BIT]) ||
                         ((ovr_q || mode_fault_flag_q) && err_ie_q);
    end
  end

endmodule

/* sim/spi_slave_model.sv */
// far-side spi slave: answers the block's master clock with a byte of its own
// assumes the bench owns its select and reply byte; idle-low clock, msb first
`timescale 1ns/1ps
module spi_slave_model (
  // serial side
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       sel_n_in,
  output logic            miso_out,
  // bench side
  input  wire logic [7:0] tx_in,
  output logic      [7:0] rx_out,
  output logic      [3:0] bits_out
);
  logic [7:0] sh_q = 8'h00;
  initial miso_out = 1'b0;
  initial rx_out = 8'h00;
  initial bits_out = 4'h0;
  // selection loads the reply and shows its msb before the first edge
  always @(negedge sel_n_in) begin
    sh_q = tx_in;
    miso_out = tx_in[7];
    bits_out = 4'h0;
  end
  // released line shows the inverse so a stale sample never passes
  always @(posedge sel_n_in) miso_out = ~miso_out;
  // capture on rising clock, msb first
  always @(posedge sck_in) if (!sel_n_in) begin
    rx_out = {rx_out[6:0], mosi_in};
    bits_out = bits_out + 4'h1;
  end
  // next bit goes out on the falling clock
  always @(negedge sck_in) if (!sel_n_in) begin
    sh_q = sh_q << 1;
    miso_out = sh_q[7];
  end
endmodule

/* sim/spi_sd_properties.sv */
// port-level checker for the serial status and data block
// assumes a classic single-cycle bus master and registered outputs
`timescale 1ns/1ps
module spi_sd_checker
  import spi_sd_pkg::*;
(
  // clock, reset and bus
  input wire logic        MCLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        CYC_IN,
  input wire logic        STB_IN,
  input wire logic        WE_IN,
  input wire logic [3:0]  ADR_IN,
  input wire logic [3:0]  SEL_IN,
  input wire logic [31:0] DAT_IN,
  input wire logic [31:0] DAT_OUT,
  input wire logic        ACK_OUT,
  // pins and request
  input wire logic        SS_N_IN,
  input wire logic        SCK_OUT,
  input wire logic        MISO_OE_OUT,
  input wire logic        SS_IS_INPUT_OUT,
  input wire logic        IRQ_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [7:0] ctrl_q, stat_q, hi_q, div;
  logic [4:0] cfg_q;
  logic       wr, rd_unm, irq_en;
  assign wr = CYC_IN && STB_IN && WE_IN && !ACK_OUT && SEL_IN[0];
  assign rd_unm = CYC_IN && STB_IN && !WE_IN && !ACK_OUT && ADR_IN == 4'hC;
  assign irq_en = ctrl_q[0] || ctrl_q[2] || stat_q[6];
  assign div = stat_q[1] ? (stat_q[0] ? DIV_CODE3 : DIV_CODE2) : (stat_q[0] ? DIV_CODE1 : DIV_CODE0);
  // shadow of what software wrote; only config bits are used
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_q <= CTRL_RESET;
      stat_q <= 8'h00;
    end else if (wr && ADR_IN == CTRL_OFFSET) begin
      ctrl_q <= DAT_IN[7:0];
    end else if (wr && ADR_IN == STATUS_OFFSET) begin
      stat_q <= DAT_IN[7:0];
    end
  end
  // delayed config lets the registered pin owner settle first
  always_ff @(posedge MCLK_IN) cfg_q <= {ctrl_q[3:0], stat_q[2]};
  // length of the current high phase of the master clock
  always_ff @(posedge MCLK_IN) hi_q <= SCK_OUT ? hi_q + 8'h01 : 8'h00;
  property p_ack_follow; CYC_IN && STB_IN && !ACK_OUT |=> ACK_OUT; endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack missing after request");
  property p_ack_pulse; ACK_OUT |=> !ACK_OUT; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_rdata_upper; ACK_OUT |-> DAT_OUT[31:8] == 24'h000000; endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits not zero");
  property p_unmapped; $past(rd_unm) |-> ACK_OUT && DAT_OUT == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_gate; !irq_en && !$past(irq_en) |-> !IRQ_OUT; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request with all enables off");
  property p_rate_half; $fell(SCK_OUT) && ctrl_q[1] |-> hi_q == div; endproperty
  a_rate_half: assert property (p_rate_half) else $error("clock half period wrong");
  property p_ss_owner; ctrl_q[3] && cfg_q == {ctrl_q[3:0], stat_q[2]} |-> SS_IS_INPUT_OUT == (!ctrl_q[1] || stat_q[2]);
  endproperty
  a_ss_owner: assert property (p_ss_owner) else $error("select pin owner wrong");
  property p_slave_hiz; (ctrl_q[3] && !ctrl_q[1] && SS_N_IN)[*4] |-> !MISO_OE_OUT; endproperty
  a_slave_hiz: assert property (p_slave_hiz) else $error("deselected slave drives data");
  c_xfer: cover property ($fell(SCK_OUT));
  c_irq: cover property ($rose(IRQ_OUT));
  c_slave: cover property (ctrl_q[3] && !ctrl_q[1] && SS_N_IN);
endmodule
bind spi_status_data_path spi_sd_checker u_spi_sd_checker (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .CYC_IN(CYC_IN),
  .STB_IN(STB_IN), .WE_IN(WE_IN), .ADR_IN(ADR_IN), .SEL_IN(SEL_IN), .DAT_IN(DAT_IN), .DAT_OUT(DAT_OUT),
  .ACK_OUT(ACK_OUT), .SS_N_IN(SS_N_IN), .SCK_OUT(SCK_OUT), .MISO_OE_OUT(MISO_OE_OUT),
  .SS_IS_INPUT_OUT(SS_IS_INPUT_OUT), .IRQ_OUT(IRQ_OUT));

/* sim/tb_top.sv */
// self-checking bench for the serial status and data block
// assumes a slave model on the serial pins and the bench as bus master
`timescale 1ns/1ps
module tb_top;
  import spi_sd_pkg::*;
  logic       mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic       sck_in = 1'b0, mosi_in = 1'b0, ss_n = 1'b1, sel_n = 1'b1;
  logic       sck, mosi, miso, ack, irq, sck_oe, mosi_oe, miso_o, miso_oe;
  logic [3:0] adr = 4'h0, bits;
  logic [7:0] ptx = 8'h00, prx, q, a, b;
  logic [31:0] wdat = 32'h00000000, rdat;
  int         n_fail = 0, checks_done = 0;
  spi_status_data_path u_spi_status_data_path (.MCLK_IN(mclk), .RST_N_IN(rst_n), .CYC_IN(cyc), .STB_IN(stb),
    .WE_IN(we), .ADR_IN(adr), .SEL_IN(4'hF), .DAT_IN(wdat), .DAT_OUT(rdat), .ACK_OUT(ack), .SCK_IN(sck_in),
    .MOSI_IN(mosi_in), .MISO_IN(miso), .SS_N_IN(ss_n), .SCK_OUT(sck), .SCK_OE_OUT(sck_oe), .MOSI_OUT(mosi),
    .MOSI_OE_OUT(mosi_oe), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe), .SS_IS_INPUT_OUT(), .IRQ_OUT(irq));
  spi_slave_model u_spi_slave_model (.sck_in(sck), .mosi_in(mosi), .sel_n_in(sel_n), .miso_out(miso),
    .tx_in(ptx), .rx_out(prx), .bits_out(bits));
  initial forever #10 mclk = ~mclk;
  // -------------------------------------------------------------------
  // bus, compare and wait helpers
  // -------------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // status layout worked out field by field
  function automatic logic [7:0] st(logic rf, ei, ov, mf, te, me, logic [1:0] rt);
    return {rf, ei, ov, mf, te, me, rt};
  endfunction
  // classic cycle: ack is sampled at a rising edge, data taken and request released there
  task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] d, output logic [7:0] r);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (ack !== 1'b1) begin
      n_fail++;
      final_report();
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e, input string nm);
    wb(1'b0, ad, 8'h00, q);
    check8(nm, e, q);
  endtask
  // polls status; a bit that never comes counts as a failure
  task automatic poll(input int idx);
    int k;
    k = 0;
    do begin
      wb(1'b0, STATUS_OFFSET, 8'h00, q);
      k++;
    end while (q[idx] !== 1'b1 && k < 1000);
    if (k >= 1000) begin
      n_fail++;
      final_report();
    end
  endtask
  // selects the partner with its reply byte, then writes the data byte without polling tx empty
  task automatic xfer(input logic [7:0] d, input logic [7:0] reply);
    @(posedge mclk);
    ptx <= reply;
    sel_n <= 1'b0;
    wb(1'b1, DATA_OFFSET, d, q);
  endtask
  task automatic pulse_ss();
    @(posedge mclk);
    ss_n <= 1'b0;
    repeat (4) @(posedge mclk);
    ss_n <= 1'b1;
  endtask
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    void'($urandom(32'hde59));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(STATUS_OFFSET, st(0, 0, 0, 0, 1, 0, 2'b00), "status reset");
    rd(CTRL_OFFSET, CTRL_RESET, "control reset");
    rd(4'hC, 8'h00, "unmapped");
    for (int c = 0; c < 4; c++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      wb(1'b1, STATUS_OFFSET, 8'(c), q);
      wb(1'b1, CTRL_OFFSET, 8'h0B, q);
      xfer(a, b);
      rd(STATUS_OFFSET, st(0, 0, 0, 0, 1, 0, 2'(c)), "tx empty refill");
      poll(ST_RX_FULL_BIT);
      check8("rx irq", 8'h01, {7'h00, irq});
      rd(DATA_OFFSET, b, "rx byte");
      check8("partner rx", a, prx);
      check8("partner bits", 8'h08, {4'h0, bits});
      rd(STATUS_OFFSET, st(0, 0, 0, 0, 1, 0, 2'(c)), "rx full clear");
      sel_n <= 1'b1;
    end
    wb(1'b1, CTRL_OFFSET, 8'h0E, q);
    rd(CTRL_OFFSET, 8'h0E, "control");
    check8("tx irq", 8'h01, {7'h00, irq});
    check8("master pins", 8'h03, {6'h00, sck_oe, mosi_oe});
    // overrun: second byte lands with the first still unread
    wb(1'b1, STATUS_OFFSET, 8'h40, q);
    wb(1'b1, CTRL_OFFSET, 8'h0A, q);
    xfer(a, b);
    poll(ST_RX_FULL_BIT);
    sel_n <= 1'b1;
    xfer(~a, ~b);
    poll(ST_OVR_BIT);
    sel_n <= 1'b1;
    rd(STATUS_OFFSET, st(1, 1, 1, 0, 1, 0, 2'b00), "overrun");
    check8("err irq", 8'h01, {7'h00, irq});
    rd(DATA_OFFSET, b, "old byte kept");
    rd(STATUS_OFFSET, st(0, 1, 0, 0, 1, 0, 2'b00), "overrun clear");
    check8("irq low", 8'h00, {7'h00, irq});
    // master mode fault, with and without detection enabled
    pulse_ss();
    rd(STATUS_OFFSET, st(0, 1, 0, 0, 1, 0, 2'b00), "fault disabled");
    wb(1'b1, STATUS_OFFSET, 8'h44, q);
    pulse_ss();
    rd(STATUS_OFFSET, st(0, 1, 0, 1, 1, 1, 2'b00), "master fault");
    check8("fault irq", 8'h01, {7'h00, irq});
    wb(1'b1, STATUS_OFFSET, 8'h40, q);
    rd(STATUS_OFFSET, st(0, 1, 0, 1, 1, 0, 2'b00), "fault kept");
    xfer(8'h5A, 8'hC3);
    rd(STATUS_OFFSET, st(0, 1, 0, 0, 1, 0, 2'b00), "fault clear");
    poll(ST_RX_FULL_BIT);
    sel_n <= 1'b1;
    rd(DATA_OFFSET, 8'hC3, "byte after fault");
    // slave deselected mid transfer
    wb(1'b1, STATUS_OFFSET, 8'h47, q);
    wb(1'b1, CTRL_OFFSET, 8'h08, q);
    a = 8'($urandom);
    wb(1'b1, DATA_OFFSET, a, q);
    @(posedge mclk);
    ss_n <= 1'b0;
    repeat (4) @(posedge mclk);
    check8("slave pins", {5'h00, 1'b0, 1'b1, a[7]}, {5'h00, sck_oe, miso_oe, miso_o});
    repeat (3) begin
      repeat (4) @(posedge mclk);
      sck_in <= 1'b1;
      mosi_in <= 1'($urandom);
      repeat (4) @(posedge mclk);
      sck_in <= 1'b0;
    end
    ss_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(STATUS_OFFSET, st(0, 1, 0, 1, 1, 1, 2'b11), "slave fault");
    final_report();
  end
endmodule
